// ==== verilog/bsspa_bridge.sv ====
// Peripheral bus bridge with two-master arbitration pins.
// Assumes synchronous inputs and a simple strobe register port.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module bsspa_bridge (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic [15:0]            reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  input  wire bsspa_pkg::bsspa_acc_t  cpu_acc,
  input  wire logic                   cpu_internal,
  output logic                        cpu_stall,
  output logic                        cpu_done,
  output logic                        cpu_unmapped,
  input  wire logic                   hold_request_in,
  output logic                        bus_request_out,
  input  wire logic                   hold_ack_in,
  output logic                        hold_ack_out,
  output logic                        hold_ack_oe,
  output logic                        in_hold,
  input  wire bsspa_pkg::bsspa_acc_t  ext_acc,
  output logic                        ext_rejected,
  output logic                        bus_dir_in,
  output bsspa_pkg::bsspa_pbus_t      periph_bus,
  output logic      [23:0]            ext_addr,
  output logic                        ext_rd_n,
  output logic                        ext_wr_n,
  output logic                        ext_bhe_n,
  output logic      [23:0]            demux_address_port
);
  import bsspa_pkg::*;

  typedef struct packed {
    logic [15:0] sel;
    logic [4:0]  cfg;
    logic        hold;
    logic [2:0]  wcnt;
    logic        busy;
    bsspa_pbus_t pb;
    logic        done;
    logic        unm;
    logic        rej;
    logic [23:0] eaddr;
    logic        erd_n;
    logic        ewr_n;
    logic        ebhe_n;
    logic [23:0] dport;
    logic [15:0] rdata;
  } bsspa_state_t;

  bsspa_state_t s_r;
  bsspa_state_t s_nxt;

  // ************************************************************
  // Window decode
  // ************************************************************
  function automatic logic [3:0] decode(input logic [23:0] a,
                                        input logic [15:0] sel);
    logic [3:0] d;
    d = '0;
    d[0] = sel[BIT_CAN1]  && ((a & WIN_CAN_MASK) == WIN_CAN1_BASE);
    d[1] = sel[BIT_CAN2]  && ((a & WIN_CAN_MASK) == WIN_CAN2_BASE);
    d[2] = sel[BIT_RAM2K] && ((a & WIN_RAM2K_MASK) == WIN_RAM2K_BASE);
    // Full 8K window although only 6K is populated
    d[3] = sel[BIT_RAM6K] && ((a & WIN_RAM6K_MASK) == WIN_RAM6K_BASE);
    return d;
  endfunction

  function automatic logic [2:0] waits(input logic [3:0] d);
    return (d[1:0] != 2'b00) ? WAIT_CAN : WAIT_RAM;
  endfunction

  logic       slave_mode;
  logic       glob_en;
  logic       vis_on;
  logic       share_ok;
  logic [3:0] cpu_dec;
  logic [3:0] ext_dec;
  logic       cpu_take;

  assign slave_mode = s_r.cfg[CFG_DIR];
  // Modules live only when both select and global enable are set
  assign glob_en    = s_r.cfg[CFG_GLOBAL_EN];
  assign vis_on     = s_r.cfg[CFG_VISIBLE] &&
                      s_r.cfg[CFG_EXT_BUS_EN];
  assign share_ok   = s_r.cfg[CFG_SHARE] && s_r.hold;
  assign cpu_dec    = glob_en ? decode(cpu_acc.addr, s_r.sel)
                              : 4'h0;
  assign ext_dec    = glob_en ? decode(ext_acc.addr, s_r.sel)
                              : 4'h0;
  // No CPU access is taken in the cycle that reports the last access, so a
  // CPU may hold req up to the edge that samples done without a repeat
  assign cpu_take   = cpu_acc.req && !cpu_internal && !s_r.hold &&
                      !s_r.busy && !s_r.done;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.unm  = 1'b0;
    s_nxt.rej  = 1'b0;
    s_nxt.pb.valid = 1'b0;
    s_nxt.pb.rd    = 1'b0;
    s_nxt.pb.wr    = 1'b0;
    s_nxt.erd_n    = 1'b1;
    s_nxt.ewr_n    = 1'b1;
    s_nxt.ebhe_n   = 1'b1;

    // Hold entry follows the partner request; in slave mode the
    // bus belongs to the master until it grants it to us.
    if (slave_mode) begin
      s_nxt.hold = hold_ack_in;
    end else begin
      s_nxt.hold = hold_request_in && !s_r.busy;
    end

    if (reg_wr) begin
      // A locked write simply does nothing, no error flag
      if (reg_addr == OFF_MODULE_SELECT && !glob_en) begin
        s_nxt.sel = reg_wdata;
      end
      if (reg_addr == OFF_SYSTEM_CONFIG) begin
        s_nxt.cfg = reg_wdata[4:0];
      end
    end
    s_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        OFF_MODULE_SELECT: s_nxt.rdata = s_r.sel;
        OFF_SYSTEM_CONFIG: s_nxt.rdata = {11'h000, s_r.cfg};
        OFF_STATUS:        s_nxt.rdata = {12'h000, s_r.busy,
                                          s_r.hold, slave_mode,
                                          glob_en};
        default:           s_nxt.rdata = 16'h0000;
      endcase
    end

    if (s_r.busy) begin
      if (s_r.wcnt == 3'h0) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.wcnt = s_r.wcnt - 3'h1;
      end
    end else if (cpu_take) begin
      // Every routed access moves the address bus
      s_nxt.eaddr = cpu_acc.addr;
      if (cpu_dec == 4'h0) begin
        s_nxt.unm  = 1'b1;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.busy     = 1'b1;
        s_nxt.wcnt     = waits(cpu_dec);
        s_nxt.pb.valid = 1'b1;
        s_nxt.pb.rd    = !cpu_acc.wr;
        s_nxt.pb.wr    = cpu_acc.wr;
        s_nxt.pb.byte_high_enable   = cpu_acc.byte_high_enable;
        s_nxt.pb.addr  = cpu_acc.addr;
        s_nxt.pb.wdata = cpu_acc.wdata;
        s_nxt.pb.sel   = cpu_dec;
        if (vis_on) begin
          s_nxt.erd_n  = cpu_acc.wr;
          s_nxt.ewr_n  = !cpu_acc.wr;
          s_nxt.ebhe_n = !cpu_acc.byte_high_enable;
          s_nxt.dport  = cpu_acc.addr;
        end
        // Without visible mode the strobes stay idle
      end
    end else if (ext_acc.req && s_r.hold) begin
      if (share_ok && ext_dec != 4'h0) begin
        s_nxt.pb.valid = 1'b1;
        s_nxt.pb.rd    = !ext_acc.wr;
        s_nxt.pb.wr    = ext_acc.wr;
        s_nxt.pb.byte_high_enable   = ext_acc.byte_high_enable;
        s_nxt.pb.addr  = ext_acc.addr;
        s_nxt.pb.wdata = ext_acc.wdata;
        s_nxt.pb.sel   = ext_dec;
      end else begin
        s_nxt.rej = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_r        <= '0;
      s_r.sel    <= RST_MODULE_SELECT;
      s_r.erd_n  <= 1'b1;
      s_r.ewr_n  <= 1'b1;
      s_r.ebhe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Internal memory cycles, flagged by cpu_internal, never stall or route here
  // Fixed windows come from constants, not registers
  assign cpu_stall    = cpu_acc.req && !cpu_internal &&
                        (s_r.hold || s_r.busy);
  // Request only while held; tiny loops may toggle it
  assign bus_request_out = s_r.hold && cpu_acc.req &&
                           !cpu_internal;
  assign hold_ack_out = !(s_r.hold && !slave_mode);
  assign hold_ack_oe  = !slave_mode;
  assign in_hold      = s_r.hold;
  assign bus_dir_in   = share_ok;
  assign cpu_done     = s_r.done;
  assign cpu_unmapped = s_r.unm;
  assign ext_rejected = s_r.rej;
  assign periph_bus   = s_r.pb;
  assign ext_addr     = s_r.eaddr;
  assign ext_rd_n     = s_r.erd_n;
  assign ext_wr_n     = s_r.ewr_n;
  assign ext_bhe_n    = s_r.ebhe_n;
  assign demux_address_port = s_r.dport;
  assign reg_rdata    = s_r.rdata;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_lock;
    @(posedge clock) disable iff (!rstn)
      (reg_wr && reg_addr == OFF_MODULE_SELECT && glob_en)
      |=> (s_r.sel == $past(s_r.sel));
  endproperty
  a_lock: assert property (p_lock) else $error("select changed");

  property p_nostrobe;
    @(posedge clock) disable iff (!rstn)
      !vis_on |=> (ext_rd_n && ext_wr_n);
  endproperty
  a_nostrobe: assert property (p_nostrobe)
    else $error("strobe without visible");

  property p_bus_request_out;
    @(posedge clock) disable iff (!rstn)
      !s_r.hold |-> !bus_request_out;
  endproperty
  a_bus_request_out: assert property (p_bus_request_out) else $error("request out of hold");

  property p_stall;
    @(posedge clock) disable iff (!rstn)
      (s_r.hold && cpu_acc.req && !cpu_internal) |-> cpu_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall in hold");

  property p_reject;
    @(posedge clock) disable iff (!rstn)
      (ext_acc.req && s_r.hold && !s_r.busy && !s_r.cfg[CFG_SHARE])
      |=> ext_rejected;
  endproperty
  a_reject: assert property (p_reject) else $error("share off taken");

  property p_canwait;
    @(posedge clock) disable iff (!rstn)
      ($rose(s_r.busy) && s_r.pb.sel[1:0] != 2'b00)
      |-> ##3 cpu_done;
  endproperty
  a_canwait: assert property (p_canwait) else $error("wait count");

  property p_unm;
    @(posedge clock) disable iff (!rstn)
      (cpu_acc.req && !cpu_internal && !s_r.busy && !s_r.hold &&
       !s_r.done && !glob_en) |=> (cpu_unmapped && !periph_bus.valid);
  endproperty
  a_unm: assert property (p_unm) else $error("disabled module hit");

  property p_oe;
    @(posedge clock) disable iff (!rstn)
      s_r.cfg[CFG_DIR] |-> !hold_ack_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("grant pin driven");

  property p_sel_open;
    @(posedge clock) disable iff (!rstn)
      (reg_wr && reg_addr == OFF_MODULE_SELECT && !glob_en)
      |=> (s_r.sel == $past(reg_wdata));
  endproperty
  a_sel_open: assert property (p_sel_open)
    else $error("select write lost");

  property p_addr;
    @(posedge clock) disable iff (!rstn)
      cpu_take |=> (ext_addr == $past(cpu_acc.addr));
  endproperty
  a_addr: assert property (p_addr)
    else $error("address bus not moved");

  property p_vis;
    @(posedge clock) disable iff (!rstn)
      (cpu_take && vis_on && cpu_dec != 4'h0)
      |=> (ext_rd_n == $past(cpu_acc.wr) && ext_wr_n == !$past(cpu_acc.wr)
           && ext_bhe_n == !$past(cpu_acc.byte_high_enable));
  endproperty
  a_vis: assert property (p_vis)
    else $error("visible strobes wrong");

  property p_dport;
    @(posedge clock) disable iff (!rstn)
      (cpu_take && vis_on && cpu_dec != 4'h0)
      |=> (demux_address_port == $past(cpu_acc.addr));
  endproperty
  a_dport: assert property (p_dport)
    else $error("demux port not driven");

  property p_internal;
    @(posedge clock) disable iff (!rstn)
      (cpu_acc.req && cpu_internal && !s_r.busy && !s_r.hold)
      |=> (!periph_bus.valid && !cpu_done);
  endproperty
  a_internal: assert property (p_internal)
    else $error("internal access routed");

  property p_share;
    @(posedge clock) disable iff (!rstn)
      (ext_acc.req && share_ok && !s_r.busy && ext_dec != 4'h0)
      |=> (periph_bus.valid && !ext_rejected);
  endproperty
  a_share: assert property (p_share)
    else $error("shared access lost");

  property p_ramwait;
    @(posedge clock) disable iff (!rstn)
      ($rose(s_r.busy) && s_r.pb.sel[1:0] == 2'b00) |-> ##1 cpu_done;
  endproperty
  a_ramwait: assert property (p_ramwait)
    else $error("ram wait count");

  property p_onehot;
    @(posedge clock) disable iff (!rstn)
      periph_bus.valid |-> $onehot(periph_bus.sel);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("windows overlap");

  property p_disabled;
    @(posedge clock) disable iff (!rstn)
      !glob_en |-> (cpu_dec == 4'h0 && ext_dec == 4'h0);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("module live while disabled");
endmodule // bsspa_bridge

// ==== verilog/bsspa_pkg.sv ====
// Constants and carrier types for the peripheral access bridge.
// Assumes one 100 MHz clock and a simple strobe register port.
// Notes on behaviour
// - Direction bit 1 selects slave, reset master
// - Slave mode turns acknowledge pin into grant
// - Request output feeds partner hold input
// - Slave request may toggle on tiny loops
// - Module windows fixed, not software programmable
// - Modules use demultiplexed cycles only
// - Modules disabled after reset until enabled
// - Cleared select bit hides module and pins
// - Select register writable only when disabled
// - Bit map and wait states, reset 0401
// - Large RAM decodes a full 8K window
// - Visible mode mirrors strobes externally
// - Visible mode drives demux address port
// - Internal memory accesses never mirrored
// - Routed accesses always change address bus
// - Visible off keeps strobes inactive
// - Visible needs external bus enabled
// - Share mode only while in hold
// - Share reverses interface direction
// - Share off rejects outside accesses
// - Request output only asserted in hold
// - Peripheral accesses stall during hold
package bsspa_pkg;
  localparam logic [15:0] OFF_MODULE_SELECT = 16'hf024;
  localparam logic [15:0] OFF_SYSTEM_CONFIG = 16'hf026;
  localparam logic [15:0] OFF_STATUS        = 16'hf028;
  localparam logic [15:0] RST_MODULE_SELECT = 16'h0401;
  localparam int          BIT_CAN1          = 0;
  localparam int          BIT_CAN2          = 1;
  localparam int          BIT_RAM2K         = 10;
  localparam int          BIT_RAM6K         = 11;
  localparam int          CFG_GLOBAL_EN     = 0;
  localparam int          CFG_VISIBLE       = 1;
  localparam int          CFG_SHARE         = 2;
  localparam int          CFG_EXT_BUS_EN    = 3;
  localparam int          CFG_DIR           = 4;
  localparam logic [2:0]  WAIT_CAN          = 3'h2;
  localparam logic [2:0]  WAIT_RAM          = 3'h0;
  // Fixed windows: base and mask per module (mask bits must match)
  localparam logic [23:0] WIN_CAN1_BASE     = 24'h00_ef00;
  localparam logic [23:0] WIN_CAN2_BASE     = 24'h00_ee00;
  localparam logic [23:0] WIN_CAN_MASK      = 24'hff_ff00;
  localparam logic [23:0] WIN_RAM2K_BASE    = 24'h00_e000;
  localparam logic [23:0] WIN_RAM2K_MASK    = 24'hff_f800;
  localparam logic [23:0] WIN_RAM6K_BASE    = 24'h00_c000;
  localparam logic [23:0] WIN_RAM6K_MASK    = 24'hff_e000;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic        byte_high_enable;
    logic [23:0] addr;
    logic [15:0] wdata;
  } bsspa_acc_t;

  typedef struct packed {
    logic        valid;
    logic        rd;
    logic        wr;
    logic        byte_high_enable;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [3:0]  sel;
  } bsspa_pbus_t;
endpackage

// ==== testbench/bsspa_partner.sv ====
// Model of the second controller sharing the external bus.
// Assumes the bridge's arbitration pins and the bench clock.
`timescale 1ns/10ps
module bsspa_partner #(
  parameter int DLY = 3
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic slave_mode,
  input  wire logic want,
  input  wire logic bus_request_out,
  output logic      hold_request_in,
  output logic      hold_ack_in
);
  int   cnt_r;
  logic own_r;
  // Partner as slave: its request feeds our hold input
  assign hold_request_in = !slave_mode && want;
  // Partner as master: high while it keeps the bus
  assign hold_ack_in = slave_mode && own_r;
  // Yields only after DLY+1 request cycles, so the slow grant path is exercised
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      own_r <= 1'b0;
      cnt_r <= 0;
    end else if (bus_request_out && own_r) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == DLY) begin
        own_r <= 1'b0;
      end
    end else if (!bus_request_out) begin
      cnt_r <= 0;
      own_r <= want;
    end
  end
endmodule // bsspa_partner

// ==== testbench/bus_share_slave_periph_access_tb.sv ====
// Self-checking bench for the peripheral access bridge.
// Assumes bsspa_pkg and the partner model are compiled first.
`timescale 1ns/10ps
module bus_share_slave_periph_access_tb;
  import bsspa_pkg::*;
  logic        clock = 1'b0, rstn = 1'b0;
  logic [15:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, cpu_internal = 1'b0;
  bsspa_acc_t  cpu_acc = '0, ext_acc = '0;
  bsspa_pbus_t periph_bus;
  logic        cpu_stall, cpu_done, cpu_unmapped, hold_request_in;
  logic        bus_request_out, hold_ack_in, hold_ack_out, hold_ack_oe;
  logic        in_hold, ext_rejected, bus_dir_in, ext_rd_n, ext_wr_n;
  logic        ext_bhe_n, slave = 1'b0, want = 1'b0, v;
  logic [23:0] ext_addr, demux_address_port, o;
  logic [15:0] cfgs [3] = '{16'h0009, 16'h000b, 16'h0003};
  int          fails = 0, n_tests = 0, seed = 19983;
  always #5 clock = ~clock;
  bsspa_bridge dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_acc(cpu_acc), .cpu_internal(cpu_internal),
    .cpu_stall(cpu_stall), .cpu_done(cpu_done), .cpu_unmapped(cpu_unmapped),
    .hold_request_in(hold_request_in), .bus_request_out(bus_request_out),
    .hold_ack_in(hold_ack_in), .hold_ack_out(hold_ack_out),
    .hold_ack_oe(hold_ack_oe), .in_hold(in_hold), .ext_acc(ext_acc),
    .ext_rejected(ext_rejected), .bus_dir_in(bus_dir_in),
    .periph_bus(periph_bus), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n), .ext_bhe_n(ext_bhe_n),
    .demux_address_port(demux_address_port));
  bsspa_partner #(.DLY(3)) peer (.clock(clock), .rstn(rstn),
    .slave_mode(slave), .want(want), .bus_request_out(bus_request_out),
    .hold_request_in(hold_request_in), .hold_ack_in(hold_ack_in));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  // Lat 0 marks an access that is expected to stall first
  task automatic acc(input logic [23:0] a, input logic w, input int lat,
                     input logic um, input logic vis);
    int n;
    logic [15:0] d;
    d = 16'($random(seed));
    @(posedge clock);
    cpu_acc <= '{1'b1, w, d[0], a, d};
    @(posedge clock);
    #1 n = 1;
    if (lat != 0 && !um) begin
      chk("periph_valid", 1, periph_bus.valid);
      chk("ext_addr", a, ext_addr);
      chk("periph_addr", a, periph_bus.addr);
      chk("periph_wr", w, periph_bus.wr);
      chk("periph_rd", !w, periph_bus.rd);
      chk("periph_wdata", d, periph_bus.wdata);
      chk("ext_rd_n", !(vis && !w), ext_rd_n);
      chk("ext_wr_n", !(vis && w), ext_wr_n);
      chk("ext_bhe_n", !(vis && d[0]), ext_bhe_n);
      if (vis) chk("demux_port", a, demux_address_port);
    end
    while (cpu_done !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n++;
    end
    chk("cpu_done", 1, cpu_done);
    if (lat != 0) chk("latency", 24'(lat), 24'(n));
    chk("unmapped", um, cpu_unmapped);
    @(posedge clock);
    cpu_acc.req <= 1'b0;
  endtask
  task automatic ext(input logic [23:0] a, input logic rej, input logic tk);
    @(posedge clock);
    ext_acc <= '{1'b1, 1'b0, 1'b0, a, 16'h0000};
    @(posedge clock);
    ext_acc.req <= 1'b0;
    #1 chk("ext_rejected", rej, ext_rejected);
    chk("periph_valid", tk, periph_bus.valid);
    if (tk) chk("periph_addr", a, periph_bus.addr);
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rd(OFF_MODULE_SELECT, RST_MODULE_SELECT);
    rd(OFF_STATUS, 16'h0000);
    acc(WIN_CAN1_BASE, 1'b0, 1, 1'b1, 1'b0);
    wr(OFF_MODULE_SELECT, 16'h0803);
    rd(OFF_MODULE_SELECT, 16'h0803);
    wr(OFF_SYSTEM_CONFIG, 16'h0009);
    wr(OFF_MODULE_SELECT, 16'h0401);
    rd(OFF_MODULE_SELECT, 16'h0803);
    rd(16'hf030, 16'h0000);
    foreach (cfgs[i]) begin
      wr(OFF_SYSTEM_CONFIG, cfgs[i]);
      v = (cfgs[i] == 16'h000b);
      for (int k = 0; k < 3; k++) begin
        o = 24'($random(seed)) & 24'h00_00fe;
        acc(WIN_CAN1_BASE | o, k[0], 4, 1'b0, v);
        acc(WIN_CAN2_BASE | o, !k[0], 4, 1'b0, v);
        acc(WIN_RAM2K_BASE | o, k[0], 1, 1'b1, 1'b0);
        acc(WIN_RAM6K_BASE | 24'h00_1f00 | o, k[0], 2, 1'b0, v);
      end
    end
    acc(24'h00_1000, 1'b0, 1, 1'b1, 1'b0);
    @(posedge clock);
    cpu_internal <= 1'b1;
    cpu_acc <= '{1'b1, 1'b0, 1'b0, WIN_CAN1_BASE, 16'h0000};
    repeat (3) @(posedge clock);
    #1 chk("periph_valid", 0, periph_bus.valid);
    chk("cpu_done", 0, cpu_done);
    @(posedge clock);
    cpu_acc.req <= 1'b0;
    cpu_internal <= 1'b0;
    want <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk("in_hold", 1, in_hold);
    chk("hold_ack_out", 0, hold_ack_out);
    chk("hold_ack_oe", 1, hold_ack_oe);
    ext(WIN_CAN1_BASE, 1'b1, 1'b0);
    wr(OFF_SYSTEM_CONFIG, 16'h000d);
    ext(WIN_CAN2_BASE, 1'b0, 1'b1);
    chk("bus_dir_in", 1, bus_dir_in);
    fork
      acc(WIN_CAN1_BASE, 1'b0, 0, 1'b0, 1'b0);
      begin
        repeat (5) @(posedge clock);
        #1 chk("cpu_stall", 1, cpu_stall);
        chk("bus_request", 1, bus_request_out);
        @(posedge clock);
        want <= 1'b0;
      end
    join
    #1 chk("bus_request", 0, bus_request_out);
    ext(WIN_CAN1_BASE, 1'b0, 1'b0);
    @(posedge clock);
    want <= 1'b1;
    slave <= 1'b1;
    wr(OFF_SYSTEM_CONFIG, 16'h0019);
    repeat (2) @(posedge clock);
    #1 chk("hold_ack_oe", 0, hold_ack_oe);
    chk("in_hold", 1, in_hold);
    acc(WIN_CAN2_BASE, 1'b1, 0, 1'b0, 1'b0);
    final_report;
  end
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    final_report;
  end
endmodule // bus_share_slave_periph_access_tb
